// ==== op_pkg.sv ====
// Constants, types and encodings for the operator panel keys and display
//==========================================================================
package op_pkg;
    // Timing: clock period, millisecond tick and counts in ticks
    localparam int CLK_NS = 4;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    localparam logic [3:0] DEB_MS = 4'ha;
    localparam logic [9:0] LONG_MS = 10'h1f4;
    localparam logic [9:0] REP_MS = 10'h032;
    localparam logic [9:0] BOOT_MS = 10'h3e8;
    localparam logic [7:0] BLINK_MS = 8'hfa;
    // Sizes and limits
    localparam logic [4:0] N_ITEMS = 5'h15;
    localparam logic [3:0] N_PAR_LAST = 4'hf;
    localparam logic [3:0] INIT_PAR = 4'h3;
    localparam logic signed [18:0] VMAX = 19'sh1869f;
    // Key bit positions in the key vector
    localparam int K_MODE = 4;
    localparam int K_INC = 3;
    localparam int K_DEC = 2;
    localparam int K_SHIFT = 1;
    localparam int K_CONF = 0;
    // Segment patterns, bit 6 = g ... bit 0 = a
    localparam logic [6:0] SEG_MINUS = 7'h40;
    localparam logic [6:0] SEG_P = 7'h73;
    localparam logic [6:0] SEG_A = 7'h77;
    localparam logic [6:0] SEG_R = 7'h50;
    localparam logic [6:0] SEG_O = 7'h5c;
    localparam logic [6:0] SEG_N = 7'h54;

    typedef struct packed {
        logic mode;
        logic inc;
        logic dec;
        logic shift;
        logic conf;
    } op_keys_t;

    typedef struct packed {
        logic [4:0] dp;
        logic [4:0][6:0] seg;
    } op_disp_t;

    typedef struct packed {
        logic valid;
        logic [3:0] addr;
        logic signed [17:0] data;
    } op_wr_t;

    typedef enum logic [2:0] {
        ST_BOOT = 3'h0,
        ST_MON = 3'h1,
        ST_PSEL = 3'h3,
        ST_EDIT = 3'h2,
        ST_ALARM = 3'h6
    } op_state_t;
endpackage

// ==== op_panel.sv ====
// Operator panel: key debounce, menu state machine and numeric display
`timescale 1ns/1ps
`default_nettype none
module op_panel #(
    parameter int TICK_CYCLES = op_pkg::TICK_CYC
) (
    input wire logic clock, // 250 MHz system clock
    input wire logic srst, // Synchronous reset, active high
    input wire op_pkg::op_keys_t keys, // Raw key pins, high when pressed
    input wire logic signed [17:0] mon_value, // Value of selected monitor item
    input wire logic [7:0] alarm_code, // Current alarm number
    output op_pkg::op_disp_t disp, // Segments and decimal points
    output op_pkg::op_wr_t wr, // Save strobe to stored settings
    output logic [4:0] mon_item // Selected monitor item
);
    //======================================================================
    // Millisecond tick
    logic [17:0] tick_cnt, next_tick_cnt;
    logic tick;
    // Free-running divider; everything slower runs on this enable
    always_comb
    begin
        tick = (tick_cnt == 18'(TICK_CYCLES - 1));
        next_tick_cnt = tick ? 18'h0 : tick_cnt + 18'h1;
    end
    always_ff @(posedge clock)
    begin
        tick_cnt <= srst ? 18'h0 : next_tick_cnt;
    end

    //======================================================================
    // Key synchronisers and debounce
    logic [4:0] key_s1, key_s2, press, rep, down;
    // Pins are asynchronous to the clock, so two flops before any use
    always_ff @(posedge clock)
    begin
        key_s1 <= srst ? 5'h0 : keys;
        key_s2 <= srst ? 5'h0 : key_s1;
    end
    for (genvar k = 0; k < 5; k++)
    begin : g_key
        logic [3:0] deb_cnt, next_deb_cnt;
        logic [9:0] hold_cnt, next_hold_cnt;
        logic db, next_db;
        // Level must hold for the debounce time; held key repeats
        always_comb
        begin
            next_deb_cnt = deb_cnt;
            next_db = db;
            next_hold_cnt = hold_cnt;
            press[k] = 1'b0;
            rep[k] = 1'b0;
            if (tick)
            begin
                if (key_s2[k] == db)
                    next_deb_cnt = 4'h0;
                else if (deb_cnt == op_pkg::DEB_MS - 4'h1)
                begin
                    next_deb_cnt = 4'h0;
                    next_db = key_s2[k];
                    press[k] = key_s2[k];
                end
                else
                    next_deb_cnt = deb_cnt + 4'h1;
                if (!db)
                    next_hold_cnt = 10'h0;
                else if (hold_cnt == op_pkg::LONG_MS - 10'h1)
                begin
                    // Reload short of threshold: repeats every REP_MS
                    next_hold_cnt = op_pkg::LONG_MS - op_pkg::REP_MS;
                    rep[k] = 1'b1;
                end
                else
                    next_hold_cnt = hold_cnt + 10'h1;
            end
        end
        always_ff @(posedge clock)
        begin
            deb_cnt <= srst ? 4'h0 : next_deb_cnt;
            hold_cnt <= srst ? 10'h0 : next_hold_cnt;
            db <= srst ? 1'b0 : next_db;
        end
        assign down[k] = db;
    end

    //======================================================================
    // Prioritised key events, one per cycle
    logic ev_mode, ev_conf, ev_shift, ev_inc, ev_dec;
    // Only increase and reduce auto-repeat
    always_comb
    begin
        ev_mode = press[op_pkg::K_MODE];
        ev_conf = !ev_mode && press[op_pkg::K_CONF];
        ev_shift = !ev_mode && !ev_conf && press[op_pkg::K_SHIFT];
        ev_inc = !ev_mode && !ev_conf && !ev_shift
            && (press[op_pkg::K_INC] || rep[op_pkg::K_INC]);
        ev_dec = !ev_mode && !ev_conf && !ev_shift && !ev_inc
            && (press[op_pkg::K_DEC] || rep[op_pkg::K_DEC]);
    end

    //======================================================================
    // Menu state machine and stored settings
    op_pkg::op_state_t state, next_state;
    logic [4:0] next_mon_item;
    logic [3:0] par_idx, next_par_idx;
    logic [2:0] edit_pos, next_edit_pos;
    logic signed [17:0] edit_val, next_edit_val;
    logic signed [17:0] par [16];
    logic signed [17:0] next_par [16];
    logic [9:0] boot_cnt, next_boot_cnt;
    logic [7:0] blink_cnt, next_blink_cnt;
    logic blink, next_blink;
    op_pkg::op_wr_t next_wr;
    logic signed [18:0] step, sum;
    // Edit step is the weight of the selected digit
    always_comb
    begin
        case (edit_pos)
            3'h0: step = 19'sh1;
            3'h1: step = 19'sha;
            3'h2: step = 19'sh64;
            3'h3: step = 19'sh3e8;
            default: step = 19'sh2710;
        endcase
        sum = ev_inc ? 19'(edit_val) + step : 19'(edit_val) - step;
    end
    // Next menu state; edits saturate at five digits either sign
    always_comb
    begin
        next_state = state;
        next_mon_item = mon_item;
        next_par_idx = par_idx;
        next_edit_pos = edit_pos;
        next_edit_val = edit_val;
        next_par = par;
        next_boot_cnt = boot_cnt;
        next_wr = '0;
        next_blink_cnt = blink_cnt;
        next_blink = blink;
        if (tick)
        begin
            next_blink_cnt = (blink_cnt == op_pkg::BLINK_MS - 8'h1) ? 8'h0 : blink_cnt + 8'h1;
            next_blink = (blink_cnt == op_pkg::BLINK_MS - 8'h1) ? !blink : blink;
        end
        case (state)
            op_pkg::ST_BOOT:
            begin
                if (tick)
                    next_boot_cnt = boot_cnt + 10'h1;
                if (tick && boot_cnt == op_pkg::BOOT_MS - 10'h1)
                begin
                    next_state = op_pkg::ST_MON;
                    next_mon_item = (par[op_pkg::INIT_PAR] < 18'(op_pkg::N_ITEMS)
                        && !par[op_pkg::INIT_PAR][17])
                        ? par[op_pkg::INIT_PAR][4:0] : 5'h0;
                end
            end
            op_pkg::ST_MON:
            begin
                if (ev_mode)
                    next_state = op_pkg::ST_PSEL;
                else if (ev_inc)
                    next_mon_item = (mon_item == op_pkg::N_ITEMS - 5'h1) ? 5'h0
                        : mon_item + 5'h1;
                else if (ev_dec)
                    next_mon_item = (mon_item == 5'h0) ? op_pkg::N_ITEMS - 5'h1
                        : mon_item - 5'h1;
            end
            op_pkg::ST_PSEL:
            begin
                if (ev_mode)
                    next_state = op_pkg::ST_ALARM;
                else if (ev_conf)
                begin
                    next_state = op_pkg::ST_EDIT;
                    next_edit_val = par[par_idx];
                    next_edit_pos = 3'h0;
                end
                else if (ev_inc)
                    next_par_idx = par_idx + 4'h1;
                else if (ev_dec)
                    next_par_idx = par_idx - 4'h1;
            end
            op_pkg::ST_EDIT:
            begin
                if (ev_mode)
                    next_state = op_pkg::ST_PSEL;
                else if (ev_conf)
                begin
                    next_par[par_idx] = edit_val;
                    next_wr = '{valid: 1'b1, addr: par_idx, data: edit_val};
                end
                else if (ev_shift)
                    next_edit_pos = (edit_pos == 3'h4) ? 3'h0 : edit_pos + 3'h1;
                else if (ev_inc || ev_dec)
                begin
                    if (sum > op_pkg::VMAX)
                        next_edit_val = 18'(op_pkg::VMAX);
                    else if (sum < -op_pkg::VMAX)
                        next_edit_val = 18'(-op_pkg::VMAX);
                    else
                        next_edit_val = 18'(sum);
                end
            end
            op_pkg::ST_ALARM:
            begin
                if (ev_mode)
                    next_state = op_pkg::ST_MON;
            end
            default: next_state = op_pkg::ST_BOOT;
        endcase
    end
    always_ff @(posedge clock)
    begin
        state <= srst ? op_pkg::ST_BOOT : next_state;
        mon_item <= srst ? 5'h0 : next_mon_item;
        par_idx <= srst ? 4'h0 : next_par_idx;
        edit_pos <= srst ? 3'h0 : next_edit_pos;
        edit_val <= srst ? 18'h0 : next_edit_val;
        boot_cnt <= srst ? 10'h0 : next_boot_cnt;
        blink_cnt <= srst ? 8'h0 : next_blink_cnt;
        blink <= srst ? 1'b0 : next_blink;
        wr <= srst ? '0 : next_wr;
        for (int i = 0; i < 16; i++)
            par[i] <= srst ? 18'h0 : next_par[i];
    end

    //======================================================================
    // Display rendering
    function automatic logic [6:0] op_seg_digit(input logic [3:0] d);
        case (d)
            4'h0: op_seg_digit = 7'h3f;
            4'h1: op_seg_digit = 7'h06;
            4'h2: op_seg_digit = 7'h5b;
            4'h3: op_seg_digit = 7'h4f;
            4'h4: op_seg_digit = 7'h66;
            4'h5: op_seg_digit = 7'h6d;
            4'h6: op_seg_digit = 7'h7d;
            4'h7: op_seg_digit = 7'h07;
            4'h8: op_seg_digit = 7'h7f;
            default: op_seg_digit = 7'h6f;
        endcase
    endfunction
    // Digit 0 is rightmost; mind forces leading zeros while editing
    function automatic op_pkg::op_disp_t op_render(input logic signed [17:0] val,
        input logic [6:0] pfx, input logic [2:0] mind);
        op_pkg::op_disp_t d;
        logic [16:0] mag;
        logic [4:0][3:0] dg;
        logic [2:0] n;
        logic [2:0] used;
        d = '0;
        mag = val[17] ? 17'(-val) : val[16:0];
        n = 3'h1;
        for (int i = 0; i < 5; i++)
        begin
            dg[i] = 4'(mag % 17'ha);
            mag = mag / 17'ha;
            if (dg[i] != 4'h0)
                n = 3'(i + 1);
        end
        if (mind > n)
            n = mind;
        for (int i = 0; i < 5; i++)
            if (3'(i) < n)
                d.seg[i] = op_seg_digit(dg[i]);
        if (val[17] && n < 3'h5)
            d.seg[n] = op_pkg::SEG_MINUS;
        else if (val[17])
            d.dp = 5'h1f;
        used = n + 3'(val[17] && n < 3'h5);
        if (pfx != 7'h0 && used < 3'h5)
            d.seg[4] = pfx;
        return d;
    endfunction

    logic signed [17:0] show_val;
    op_pkg::op_disp_t next_disp;
    // Pick what to show; the edit digit blanks on the blink phase
    always_comb
    begin
        show_val = 18'h0;
        next_disp = '0;
        case (state)
            op_pkg::ST_BOOT:
            begin
                next_disp.seg = {op_pkg::SEG_P, op_pkg::SEG_R, op_pkg::SEG_O,
                    op_pkg::SEG_N, 7'h0};
                next_disp.dp = 5'h08;
            end
            op_pkg::ST_MON:
            begin
                show_val = mon_value;
                next_disp = op_render(mon_value,
                    (mon_item == 5'h0) ? op_pkg::SEG_R : 7'h0, 3'h1);
            end
            op_pkg::ST_PSEL:
            begin
                show_val = 18'(par_idx);
                next_disp = op_render(18'(par_idx), op_pkg::SEG_P, 3'h1);
            end
            op_pkg::ST_EDIT:
            begin
                show_val = edit_val;
                next_disp = op_render(edit_val, 7'h0, edit_pos + 3'h1);
                if (blink)
                    next_disp.seg[edit_pos] = 7'h0;
            end
            op_pkg::ST_ALARM:
            begin
                show_val = 18'(alarm_code);
                next_disp = op_render(18'(alarm_code), op_pkg::SEG_A, 3'h1);
            end
            default: next_disp = '0;
        endcase
    end
    always_ff @(posedge clock)
    begin
        disp <= srst ? '0 : next_disp;
    end

    //======================================================================
    // Checks
    property p_boot_end;
        @(posedge clock) disable iff (srst)
        state == op_pkg::ST_BOOT && tick && boot_cnt == op_pkg::BOOT_MS - 10'h1
            |=> state == op_pkg::ST_MON;
    endproperty
    a_boot_end: assert property (p_boot_end) else $error("boot did not end in monitor");
    property p_mode_back;
        @(posedge clock) disable iff (srst)
        state == op_pkg::ST_EDIT && ev_mode |=> state == op_pkg::ST_PSEL;
    endproperty
    a_mode_back: assert property (p_mode_back) else $error("mode did not leave edit");
    property p_mode_cycle;
        @(posedge clock) disable iff (srst)
        state == op_pkg::ST_MON && ev_mode |=> state == op_pkg::ST_PSEL
            ##1 disp.seg[4] == op_pkg::SEG_P;
    endproperty
    a_mode_cycle: assert property (p_mode_cycle) else $error("mode did not advance");
    property p_inc_item;
        @(posedge clock) disable iff (srst)
        state == op_pkg::ST_MON && ev_inc && mon_item < 5'h14
            |=> mon_item == $past(mon_item) + 5'h1;
    endproperty
    a_inc_item: assert property (p_inc_item) else $error("item not incremented");
    property p_dec_par;
        @(posedge clock) disable iff (srst)
        state == op_pkg::ST_PSEL && ev_dec |=> par_idx == $past(par_idx) - 4'h1;
    endproperty
    a_dec_par: assert property (p_dec_par) else $error("parameter not decremented");
    property p_shift;
        @(posedge clock) disable iff (srst)
        state == op_pkg::ST_EDIT && ev_shift && edit_pos < 3'h4
            |=> edit_pos == $past(edit_pos) + 3'h1;
    endproperty
    a_shift: assert property (p_shift) else $error("edit digit did not move");
    property p_commit;
        @(posedge clock) disable iff (srst)
        state == op_pkg::ST_EDIT && ev_conf |=> wr.valid && wr.data == $past(edit_val)
            ##1 par[$past(par_idx, 2)] == $past(edit_val, 2);
    endproperty
    a_commit: assert property (p_commit) else $error("edited value not saved");
    property p_neg_dp;
        @(posedge clock) disable iff (srst)
        disp.dp == 5'h1f |-> $past(show_val[17]);
    endproperty
    a_neg_dp: assert property (p_neg_dp) else $error("points lit for non-negative");
    // Ticks the increase key has stood down, kept apart from the repeat reload
    logic [9:0] held_ticks, next_held_ticks;
    always_comb
    begin
        next_held_ticks = held_ticks;
        if (tick)
            next_held_ticks = !down[op_pkg::K_INC] ? 10'h0
                : (held_ticks == 10'h3ff) ? held_ticks : held_ticks + 10'h1;
    end
    always_ff @(posedge clock)
    begin
        held_ticks <= srst ? 10'h0 : next_held_ticks;
    end
    property p_rep_held;
        @(posedge clock) disable iff (srst)
        rep[op_pkg::K_INC] |-> down[op_pkg::K_INC] && tick
            && held_ticks >= op_pkg::LONG_MS - 10'h1;
    endproperty
    a_rep_held: assert property (p_rep_held) else $error("repeat without held key");
endmodule
`default_nettype wire

// ==== op_operator_model.sv ====
// Behavioural operator who presses the panel keys, with contact bounce
`timescale 1ns/1ps
`default_nettype none
module op_operator_model #(
    parameter int TICK = 4
) (
    input wire logic clock, // System clock, pins change on its falling edge
    output var op_pkg::op_keys_t keys // Key pins, high when pressed
);
    logic [4:0] pins;

    //==========================================================================
    // Pin drive
    // Pins start released so the panel never sees an unknown level
    initial pins = 5'h00;
    always_comb keys = pins;

    // Wait a number of debounce ticks
    task automatic wait_ticks(input int n);
        repeat (n * TICK) @(negedge clock);
    endtask

    // Press with bounce shorter than debounce, hold, release and settle
    task automatic press(input int k, input int hold);
        for (int i = 0; i < 4; i++)
        begin
            pins[k] = ~pins[k];
            wait_ticks(2);
        end
        pins[k] = 1'b1;
        wait_ticks(hold);
        pins[k] = 1'b0;
        // Release must be stable before the next press can count
        wait_ticks(16);
    endtask

    // A short glitch that must never count as a press
    task automatic glitch(input int k);
        pins[k] = 1'b1;
        wait_ticks(5);
        pins[k] = 1'b0;
        wait_ticks(16);
    endtask
endmodule
`default_nettype wire

// ==== test_operator_panel_keys_display.sv ====
// Self-checking testbench of the operator panel keys and display
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin mismatches++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, gt); end end
module test_operator_panel_keys_display;
    localparam int TICK = 4;
    localparam int CEIL = 60000;
    logic clock;
    logic srst;
    op_pkg::op_keys_t keys;
    logic signed [17:0] mon_value;
    logic [7:0] alarm_code;
    op_pkg::op_disp_t disp;
    op_pkg::op_wr_t wr;
    op_pkg::op_wr_t wr_last;
    logic [4:0] mon_item;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    int wr_count = 0;

    //==========================================================================
    // Clock, design and operator
    initial clock = 1'b0;
    always #2 clock = ~clock;

    op_panel #(.TICK_CYCLES(TICK)) i_dut (
        .clock(clock),
        .srst(srst),
        .keys(keys),
        .mon_value(mon_value),
        .alarm_code(alarm_code),
        .disp(disp),
        .wr(wr),
        .mon_item(mon_item)
    );

    op_operator_model #(.TICK(TICK)) i_op (
        .clock(clock),
        .keys(keys)
    );

    // Save strobes are collected here since they stand for one cycle only
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (wr.valid === 1'b1)
        begin
            wr_count <= wr_count + 1;
            wr_last <= wr;
        end
    end

    // A hang ends the run as a failure
    always @(negedge clock)
    begin
        if (cycles >= CEIL)
        begin
            mismatches++;
            summarize();
        end
    end

    //==========================================================================
    // Helpers
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Short press of one key
    task automatic tap(input int k);
        i_op.press(k, 20);
    endtask

    // Drive a monitored value and let the display settle
    task automatic show(input logic signed [17:0] v);
        mon_value = v;
        repeat (4) @(negedge clock);
    endtask

    //==========================================================================
    // Scenarios
    // Boot message, keys ignored during boot, then monitoring of item 0
    task automatic t_boot();
        @(negedge clock);
        `CHK("boot seg4", op_pkg::SEG_P, disp.seg[4])
        `CHK("boot seg3", op_pkg::SEG_R, disp.seg[3])
        `CHK("boot seg1", op_pkg::SEG_N, disp.seg[1])
        `CHK("boot dp", 5'h08, disp.dp)
        tap(op_pkg::K_INC);
        `CHK("boot item", 5'h00, mon_item)
        i_op.wait_ticks(1000);
        `CHK("first item", 5'h00, mon_item)
        `CHK("mon prefix", op_pkg::SEG_R, disp.seg[4])
    endtask

    // Signs, all decimal points and prefix dropping
    task automatic t_display();
        show(18'sd5);
        `CHK("pos blank", 7'h00, disp.seg[2])
        `CHK("pos dp", 5'h00, disp.dp)
        show(-18'sd5);
        `CHK("minus pos", op_pkg::SEG_MINUS, disp.seg[1])
        `CHK("prefix kept", op_pkg::SEG_R, disp.seg[4])
        show(-18'sd1234);
        `CHK("minus msd", op_pkg::SEG_MINUS, disp.seg[4])
        show(-18'sd12345);
        `CHK("neg dp", 5'h1f, disp.dp)
        show(18'sd12345);
        `CHK("no prefix", 1'b1, disp.seg[4] !== op_pkg::SEG_R)
        `CHK("five dp", 5'h00, disp.dp)
        show(18'sd5);
    endtask

    // Monitor item stepping with wrap and a rejected glitch
    task automatic t_monitor();
        tap(op_pkg::K_INC);
        `CHK("inc item", 5'h01, mon_item)
        tap(op_pkg::K_DEC);
        `CHK("dec item", 5'h00, mon_item)
        tap(op_pkg::K_DEC);
        `CHK("wrap low", 5'h14, mon_item)
        tap(op_pkg::K_INC);
        `CHK("wrap high", 5'h00, mon_item)
        i_op.glitch(op_pkg::K_INC);
        `CHK("glitch", 5'h00, mon_item)
    endtask

    // Mode key walks monitor, parameter and alarm modes
    task automatic t_modes();
        tap(op_pkg::K_MODE);
        `CHK("param mode", op_pkg::SEG_P, disp.seg[4])
        tap(op_pkg::K_MODE);
        `CHK("alarm mode", op_pkg::SEG_A, disp.seg[4])
        tap(op_pkg::K_MODE);
        `CHK("back mon", op_pkg::SEG_R, disp.seg[4])
    endtask

    // Edit parameter 1 with shifted digits and save twice
    task automatic t_edit();
        int n;
        tap(op_pkg::K_MODE);
        tap(op_pkg::K_INC);
        tap(op_pkg::K_CONF);
        tap(op_pkg::K_INC);
        tap(op_pkg::K_SHIFT);
        tap(op_pkg::K_INC);
        tap(op_pkg::K_INC);
        n = wr_count;
        tap(op_pkg::K_CONF);
        `CHK("save count", n + 1, wr_count)
        `CHK("save addr", 4'h1, wr_last.addr)
        `CHK("save data", 18'sd21, wr_last.data)
        for (int i = 0; i < 4; i++)
            tap(op_pkg::K_SHIFT);
        tap(op_pkg::K_INC);
        tap(op_pkg::K_CONF);
        `CHK("wrap data", 18'sd22, wr_last.data)
        `CHK("two saves", n + 2, wr_count)
        tap(op_pkg::K_MODE);
        `CHK("edit back", op_pkg::SEG_P, disp.seg[4])
        tap(op_pkg::K_MODE);
        tap(op_pkg::K_MODE);
        `CHK("mon again", op_pkg::SEG_R, disp.seg[4])
    endtask

    // Held keys repeat after the long press threshold
    task automatic t_repeat();
        i_op.press(op_pkg::K_INC, 580);
        `CHK("inc held", 5'h03, mon_item)
        i_op.press(op_pkg::K_DEC, 530);
        `CHK("dec held", 5'h01, mon_item)
    endtask

    //==========================================================================
    // Main sequence
    initial
    begin
        srst = 1'b1;
        mon_value = 18'sd5;
        alarm_code = 8'h07;
        repeat (12) @(negedge clock);
        srst = 1'b0;
        t_boot();
        t_display();
        t_monitor();
        t_modes();
        t_edit();
        t_repeat();
        summarize();
    end
endmodule
`default_nettype wire
